// ==== verilog/clk_src_pkg.sv ====
// Purpose: constants shared by the clock source block files
// Assumes: 32-bit apb data, byte registers in the low bits
// Notes:   offsets are byte addresses of aligned words
package clk_src_pkg;
   // =====================================================================
   // register map
   localparam logic [7:0] ctrl_one_off    = 8'h00;
   localparam logic [7:0] ctrl_two_off    = 8'h04;
   localparam logic [7:0] trim_off        = 8'h08;
   localparam logic [7:0] status_off      = 8'h0c;
   localparam logic [7:0] control_off     = 8'h10;
   // =====================================================================
   // reset values
   localparam logic [7:0] ctrl_one_rst    = 8'h04;
   localparam logic [7:0] ctrl_two_rst    = 8'h40;
   localparam logic [7:0] trim_rst        = 8'h80;
   localparam logic       fine_trim_rst   = 1'b0;
   // =====================================================================
   // field positions
   localparam int         src_sel_pos     = 6;
   localparam int         ref_div_pos     = 3;
   localparam int         int_ref_sel_pos = 2;
   localparam int         int_clk_en_pos  = 1;
   localparam int         int_stop_en_pos = 0;
   localparam int         bus_div_pos     = 6;
   localparam int         range_pos       = 5;
   localparam int         gain_pos        = 4;
   localparam int         lowpower_pos    = 3;
   localparam int         ext_req_pos     = 2;
   localparam int         ext_clk_en_pos  = 1;
   localparam int         ext_stop_en_pos = 0;
   // =====================================================================
   // clock source encodings
   localparam logic [1:0] src_loop        = 2'h0;
   localparam logic [1:0] src_internal    = 2'h1;
   localparam logic [1:0] src_external    = 2'h2;
   // =====================================================================
   // operating modes
   typedef enum logic [2:0] {
      locked_internal_mode,
      locked_external_mode,
      bypass_internal_mode,
      bypass_internal_lowpower_mode,
      bypass_external_mode,
      bypass_external_lowpower_mode,
      stop_mode
   } mode_t;
endpackage

// ==== verilog/pow2_divider.sv ====
// Purpose: power-of-two clock enable divider
// Assumes: input is a one-cycle enable pulse train
// Notes:   shift 0 passes every input pulse
`timescale 1ns/100ps
module pow2_divider (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic       in_en,
   input  wire logic [2:0] shift,
   output logic            out_en
);
   logic [6:0] count_r;
   logic [6:0] mask;

   // =====================================================================
   // count input pulses, emit one per 2**shift
   assign mask = 7'((8'h01 << shift) - 8'h01);
   assign out_en = run & in_en & ((count_r & mask) == 7'h00);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= 7'h00;
      end else if (!run) begin
         count_r <= 7'h00;
      end else if (in_en) begin
         count_r <= (count_r + 7'h01) & mask;
      end
   end
endmodule

// ==== verilog/mode_decoder.sv ====
// Purpose: decode the operating mode from control fields
// Assumes: stop request is a level from the power controller
// Notes:   reserved source code behaves as the loop source
`timescale 1ns/100ps
module mode_decoder (
   input  wire logic [1:0]         clock_source_select,
   input  wire logic               internal_reference_select,
   input  wire logic               lowpower_select,
   input  wire logic               background_debug,
   input  wire logic               stop_req,
   output clk_src_pkg::mode_t      mode,
   output logic                    loop_enable,
   output logic [1:0]              eff_source
);
   // =====================================================================
   // mode and loop enable
   always_comb begin
      eff_source = clock_source_select;
      if (clock_source_select == 2'h3) begin
         eff_source = clk_src_pkg::src_loop;
      end
      loop_enable = 1'b1;
      if (stop_req) begin
         mode = clk_src_pkg::stop_mode;
         loop_enable = 1'b0;
      end else if (eff_source == clk_src_pkg::src_loop) begin
         mode = internal_reference_select ?
                clk_src_pkg::locked_internal_mode :
                clk_src_pkg::locked_external_mode;
      end else begin
         loop_enable = !lowpower_select || background_debug;
         if (eff_source == clk_src_pkg::src_internal) begin
            mode = loop_enable ? clk_src_pkg::bypass_internal_mode :
                   clk_src_pkg::bypass_internal_lowpower_mode;
         end else begin
            mode = loop_enable ? clk_src_pkg::bypass_external_mode :
                   clk_src_pkg::bypass_external_lowpower_mode;
         end
      end
   end
endmodule

// ==== verilog/clock_source_block.sv ====
// Purpose: clock source selector around a frequency-locked loop
// Assumes: source clocks arrive as one-cycle enable pulses on pclk
// Notes:   clock outputs are enable pulses, not real clocks
//          references kept in stop follow the settings at stop entry
//          the reserved source code reads back but acts as the loop
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
module clock_source_block (
   // apb slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // source ticks and system levels
   input  wire logic        internal_ref_en,
   input  wire logic        external_ref_en,
   input  wire logic        controlled_oscillator_en,
   input  wire logic        oscillator_ready_flag,
   input  wire logic        background_debug,
   input  wire logic        stop_req,
   // clock pulses and loop control
   output logic             final_output_clock,
   output logic             bus_clock_en,
   output logic             debug_clock,
   output logic             loop_enable,
   output logic             loop_reference_en,
   output logic [8:0]       internal_trim,
   output logic             internal_clock_out,
   output logic             external_clock_out,
   output logic             internal_ref_run,
   // crystal oscillator control and mode status
   output logic             oscillator_gain_select,
   output logic             oscillator_range_select,
   output logic             external_source_request,
   output logic             external_clock_enable,
   output logic             external_stop_enable,
   output logic [2:0]       mode_status
);
   // registers
   logic [7:0]          ctrl_one_r;
   logic [7:0]          ctrl_two_r;
   logic [7:0]          trim_r;
   logic                fine_trim_r;
   logic                dbg_toggle_r;
   logic                bus_toggle_r;
   logic                stop_r;
   logic                stop_int_on_r;
   logic                stop_ext_on_r;
   // decode, selection and reference control
   logic                wr_en;
   logic                rd_hit;
   logic [1:0]          eff_source;
   logic                selected_en;
   logic                ref_sel_en;
   logic                out_en;
   logic                int_ref_on;
   logic                ext_ref_on;
   logic                ext_in_use;
   logic                int_in_use;
   logic                int_stop_keep;
   logic                ext_stop_keep;
   clk_src_pkg::mode_t  mode;

   // =====================================================================
   // apb slave: zero wait states, error on unmapped address
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == clk_src_pkg::ctrl_one_off) ||
               (a == clk_src_pkg::ctrl_two_off) ||
               (a == clk_src_pkg::trim_off) ||
               (a == clk_src_pkg::status_off) ||
               (a == clk_src_pkg::control_off);
   endfunction

   // a reference stays on in stop if allowed and enabled or in use
   function automatic logic keep_in_stop(input logic stop_en,
                                         input logic clk_en,
                                         input logic in_use);
      keep_in_stop = stop_en & (clk_en | in_use);
   endfunction

   assign pready  = 1'b1;
   assign rd_hit  = mapped(paddr);
   assign pslverr = psel & penable & ~rd_hit;
   assign wr_en   = psel & penable & pwrite & rd_hit;

   // control registers, reset into locked internal mode
   // writes land on the access edge of a mapped address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_one_r <= clk_src_pkg::ctrl_one_rst;
         ctrl_two_r <= clk_src_pkg::ctrl_two_rst;
      end else if (wr_en) begin
         if (paddr == clk_src_pkg::ctrl_one_off) begin
            ctrl_one_r <= pwdata[7:0];
         end
         if (paddr == clk_src_pkg::ctrl_two_off) begin
            ctrl_two_r <= pwdata[7:0];
         end
      end
   end

   // nine trim bits: eight coarse plus one fine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trim_r      <= clk_src_pkg::trim_rst;
         fine_trim_r <= clk_src_pkg::fine_trim_rst;
      end else if (wr_en) begin
         if (paddr == clk_src_pkg::trim_off) begin
            trim_r <= pwdata[7:0];
         end
         if (paddr == clk_src_pkg::status_off) begin
            fine_trim_r <= pwdata[0];
         end
      end
   end

   // read data from a register
   // loaded in the setup cycle so it stands through the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            clk_src_pkg::ctrl_one_off: prdata <= {24'h00_0000, ctrl_one_r};
            clk_src_pkg::ctrl_two_off: prdata <= {24'h00_0000, ctrl_two_r};
            clk_src_pkg::trim_off:     prdata <= {24'h00_0000, trim_r};
            clk_src_pkg::status_off:   prdata <= {24'h00_0000, 3'h0,
               ctrl_one_r[clk_src_pkg::int_ref_sel_pos], eff_source,
               oscillator_ready_flag, fine_trim_r};
            clk_src_pkg::control_off:  prdata <= {29'h0000_0000, mode};
            default:                   prdata <= 32'h0000_0000;
         endcase
      end
   end

   // =====================================================================
   // mode decode
   mode_decoder u_mode (
      .clock_source_select       (ctrl_one_r[clk_src_pkg::src_sel_pos +: 2]),
      .internal_reference_select (ctrl_one_r[clk_src_pkg::int_ref_sel_pos]),
      .lowpower_select           (ctrl_two_r[clk_src_pkg::lowpower_pos]),
      .background_debug          (background_debug),
      .stop_req                  (stop_req),
      .mode                      (mode),
      .loop_enable               (loop_enable),
      .eff_source                (eff_source)
   );

   // mode shown to software and to the outside
   assign mode_status = mode;

   // =====================================================================
   // reference state captured when entering stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_r        <= 1'b0;
         stop_int_on_r <= 1'b0;
         stop_ext_on_r <= 1'b0;
      end else begin
         stop_r <= stop_req;
         if (stop_req && !stop_r) begin
            stop_int_on_r <= int_stop_keep;
            stop_ext_on_r <= ext_stop_keep;
         end
      end
   end

   // references in use by the run mode, decoded from the fields alone
   // so that the answer still holds on the edge that enters stop
   assign int_in_use = (eff_source == clk_src_pkg::src_internal) ||
                       ((eff_source == clk_src_pkg::src_loop) &&
                        ctrl_one_r[clk_src_pkg::int_ref_sel_pos]);
   assign ext_in_use = (eff_source == clk_src_pkg::src_external) ||
                       ((eff_source == clk_src_pkg::src_loop) &&
                        !ctrl_one_r[clk_src_pkg::int_ref_sel_pos]);

   // live stop decision for each reference
   assign int_stop_keep = keep_in_stop(
      ctrl_one_r[clk_src_pkg::int_stop_en_pos],
      ctrl_one_r[clk_src_pkg::int_clk_en_pos], int_in_use);
   assign ext_stop_keep = keep_in_stop(
      ctrl_two_r[clk_src_pkg::ext_stop_en_pos],
      ctrl_two_r[clk_src_pkg::ext_clk_en_pos], ext_in_use);

   // reference enables, first edge of stop uses the live decision
   assign int_ref_on = stop_req ?
      (stop_r ? stop_int_on_r : int_stop_keep) :
      (ctrl_one_r[clk_src_pkg::int_clk_en_pos] | int_in_use);
   assign ext_ref_on = stop_req ?
      (stop_r ? stop_ext_on_r : ext_stop_keep) :
      (ctrl_two_r[clk_src_pkg::ext_clk_en_pos] | ext_in_use);
   assign internal_ref_run   = int_ref_on;
   // gated reference clocks handed to on-chip users
   assign internal_clock_out = internal_ref_en & int_ref_on &
                               ctrl_one_r[clk_src_pkg::int_clk_en_pos];
   assign external_clock_out = external_ref_en & ext_ref_on &
                               ctrl_two_r[clk_src_pkg::ext_clk_en_pos];
   // trim word for the internal reference
   assign internal_trim      = {trim_r, fine_trim_r};

   // =====================================================================
   // oscillator control outputs
   assign oscillator_gain_select  = ctrl_two_r[clk_src_pkg::gain_pos];
   assign oscillator_range_select = ctrl_two_r[clk_src_pkg::range_pos];
   assign external_source_request = ctrl_two_r[clk_src_pkg::ext_req_pos];
   assign external_clock_enable   = ext_ref_on;
   assign external_stop_enable    = ctrl_two_r[clk_src_pkg::ext_stop_en_pos];

   // =====================================================================
   // loop reference: chosen reference through the reference divider
   assign ref_sel_en = ctrl_one_r[clk_src_pkg::int_ref_sel_pos] ?
                       internal_ref_en : external_ref_en;

   pow2_divider u_ref_div (
      .clk    (pclk),
      .rst_n  (presetn),
      .run    (loop_enable),
      .in_en  (ref_sel_en),
      .shift  (ctrl_one_r[clk_src_pkg::ref_div_pos +: 3]),
      .out_en (loop_reference_en)
   );

   // =====================================================================
   // source select and bus divider
   always_comb begin
      selected_en = 1'b0;
      unique case (eff_source)
         clk_src_pkg::src_internal: selected_en = internal_ref_en;
         clk_src_pkg::src_external: selected_en = external_ref_en;
         default: selected_en = controlled_oscillator_en;
      endcase
   end

   pow2_divider u_bus_div (
      .clk    (pclk),
      .rst_n  (presetn),
      .run    (~stop_req),
      .in_en  (selected_en),
      .shift  ({1'b0, ctrl_two_r[clk_src_pkg::bus_div_pos +: 2]}),
      .out_en (out_en)
   );

   // output clock pulse registered; bus enable every second one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         final_output_clock <= 1'b0;
         bus_clock_en       <= 1'b0;
         bus_toggle_r       <= 1'b0;
      end else begin
         final_output_clock <= out_en;
         bus_clock_en       <= out_en & bus_toggle_r;
         if (out_en) begin
            bus_toggle_r <= ~bus_toggle_r;
         end
      end
   end

   // debug clock: oscillator divided by two while the loop runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbg_toggle_r <= 1'b0;
         debug_clock  <= 1'b0;
      end else if (!loop_enable) begin
         dbg_toggle_r <= 1'b0;
         debug_clock  <= 1'b0;
      end else begin
         if (controlled_oscillator_en) begin
            dbg_toggle_r <= ~dbg_toggle_r;
         end
         debug_clock <= controlled_oscillator_en & dbg_toggle_r;
      end
   end
endmodule

// ==== test/fll_far_side.sv ====
// Purpose: far side model: reference, oscillator and crystal ticks
// Assumes: ticks are one-cycle enables on pclk
// Notes:   a source that is not enabled stays quiet
`timescale 1ns/100ps
module fll_far_side (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic internal_ref_run,
   input  wire logic external_clock_enable,
   input  wire logic loop_enable,
   output logic      internal_ref_en,
   output logic      external_ref_en,
   output logic      controlled_oscillator_en,
   output logic      oscillator_ready_flag
);
   logic [7:0] tick_r;
   // ====================================================================
   // free running phase counter and crystal start-up flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_r <= 8'h00;
         oscillator_ready_flag <= 1'b0;
      end else begin
         tick_r <= tick_r + 8'h01;
         if (tick_r == 8'h80) oscillator_ready_flag <= 1'b1;
      end
   end
   // internal at pclk/4 (6.25 MHz), external at pclk/8 (3.125 MHz)
   assign internal_ref_en = internal_ref_run && (tick_r[1:0] == 2'h0);
   assign external_ref_en = external_clock_enable &&
                            (tick_r[2:0] == 3'h3);
   // a disabled loop oscillator stops ticking
   assign controlled_oscillator_en = loop_enable && tick_r[0];
endmodule

// ==== test/fll_checker.sv ====
// Purpose: port assertions for the clock source block
// Assumes: a single pclk domain
// Notes:   clock outputs are enable pulses
`timescale 1ns/100ps
module fll_checker (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       stop_req,
   input wire logic       internal_ref_en,
   input wire logic       external_ref_en,
   input wire logic       controlled_oscillator_en,
   input wire logic       final_output_clock,
   input wire logic       bus_clock_en,
   input wire logic       debug_clock,
   input wire logic       loop_enable,
   input wire logic       loop_reference_en,
   input wire logic [2:0] mode_status
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ====================================================================
   // mode and clock relations
   a_reset_mode: assert property (
      $rose(presetn) && !stop_req |-> mode_status == 3'h0)
      else $error("mode after reset is not locked internal");
   a_bus_half: assert property (
      bus_clock_en |-> final_output_clock)
      else $error("bus pulse without output pulse");
   a_output_cause: assert property (
      final_output_clock |->
      $past(internal_ref_en || external_ref_en || controlled_oscillator_en))
      else $error("output pulse without source tick");
   a_debug_tick: assert property (
      debug_clock |-> $past(controlled_oscillator_en) ##1 !debug_clock)
      else $error("debug pulse not from oscillator tick");
   a_ref_gated: assert property (
      loop_reference_en |->
      loop_enable && (internal_ref_en || external_ref_en))
      else $error("loop reference pulse without cause");
   a_locked_loop: assert property (
      mode_status inside {3'h0, 3'h1} |-> loop_enable)
      else $error("loop off in locked mode");
   a_bypass_loop: assert property (
      mode_status inside {3'h2, 3'h4} |-> loop_enable)
      else $error("loop off in bypass mode");
   a_lowpower_off: assert property (
      mode_status inside {3'h3, 3'h5} |-> !loop_enable)
      else $error("loop on in low power bypass");
   a_stop_quiet: assert property (
      stop_req && $past(stop_req) |-> mode_status == 3'h6 &&
      !final_output_clock && !debug_clock && !bus_clock_en)
      else $error("clock pulse in stop mode");
endmodule

// ==== test/clock_source_block_tb_top.sv ====
// Purpose: apb driven bench for the clock source block
// Assumes: no wait states are assumed, pready is polled
// Notes:   pulse rates are counted over fixed windows
`timescale 1ns/100ps
module clock_source_block_tb_top;
   logic        pclk, presetn, psel, penable, pwrite, rerr, pready, pslverr;
   logic        background_debug, stop_req, internal_ref_en, external_ref_en;
   logic        controlled_oscillator_en, oscillator_ready_flag;
   logic        final_output_clock, bus_clock_en, debug_clock, loop_enable;
   logic        loop_reference_en, internal_clock_out, external_clock_out;
   logic        internal_ref_run, oscillator_gain_select, external_stop_enable;
   logic        oscillator_range_select, external_source_request;
   logic        external_clock_enable, regulator_stop_enable;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdata;
   logic [8:0]  internal_trim;
   logic [2:0]  mode_status;
   int          fail_count, check_count, cnt[4], d[4];
   // {ctrl one, ctrl two, mode, loop on, output pulses in 256 cycles}
   localparam logic [27:0] mt [7] = '{28'h044_0140, 28'h004_0340,
      28'h444_0520, 28'h444_8620, 28'h804_0910, 28'h804_8a10, 28'hc44_0140};
   clock_source_block u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .internal_ref_en,
      .external_ref_en, .controlled_oscillator_en, .oscillator_ready_flag,
      .background_debug, .stop_req, .final_output_clock, .bus_clock_en,
      .debug_clock, .loop_enable, .loop_reference_en, .internal_trim,
      .internal_clock_out, .external_clock_out, .internal_ref_run,
      .oscillator_gain_select, .oscillator_range_select,
      .external_source_request, .external_clock_enable,
      .external_stop_enable, .mode_status);
   fll_far_side u_far (.pclk, .presetn, .internal_ref_run,
      .external_clock_enable, .loop_enable, .internal_ref_en,
      .external_ref_en, .controlled_oscillator_en, .oscillator_ready_flag);
   // ====================================================================
   // clock and pulse counters
   always #20 pclk = ~pclk;
   always @(posedge pclk) begin
      cnt[0] <= cnt[0] + int'(final_output_clock);
      cnt[1] <= cnt[1] + int'(bus_clock_en);
      cnt[2] <= cnt[2] + int'(debug_clock);
      cnt[3] <= cnt[3] + int'(loop_reference_en);
   end
   // ====================================================================
   // checking and bus tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic near(input string nm, input int s, e);
      int t;
      t = (e == 0) ? 0 : 1;
      check(nm, (s >= e - t && s <= e + t) ? e : s, e);
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input int dv);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= dv;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         complete_run();
      end
      @(posedge pclk); // let a written value settle before any check
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input int e);
      xfer(1'b0, a, 0);
      check(nm, rdata, e);
   endtask
   task automatic measure(input int n);
      int s[4];
      repeat (4) @(posedge pclk);
      s = cnt;
      repeat (n) @(posedge pclk);
      foreach (d[i]) d[i] = cnt[i] - s[i];
   endtask
   // ====================================================================
   // main sequence
   initial begin
      {pclk, presetn, psel, penable, pwrite, background_debug} = 6'h00;
      {stop_req, regulator_stop_enable, paddr, pwdata} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl one", clk_src_pkg::ctrl_one_off, 32'h0000_0004);
      rd("ctrl two", clk_src_pkg::ctrl_two_off, 32'h0000_0040);
      rd("trim", clk_src_pkg::trim_off, 32'h0000_0080);
      check("trim out", {23'h0, internal_trim}, 32'h0000_0100);
      rd("unmapped", 8'h14, 0);
      check("slverr", {31'h0, rerr}, 32'h0000_0001);
      foreach (mt[i]) begin
         xfer(1'b1, clk_src_pkg::ctrl_one_off, mt[i][27:20]);
         xfer(1'b1, clk_src_pkg::ctrl_two_off, mt[i][19:12]);
         measure(256);
         rd("mode", clk_src_pkg::control_off, mt[i][11:9]);
         check("mstat", {29'h0, mode_status}, mt[i][11:9]);
         check("loop", {31'h0, loop_enable}, mt[i][8]);
         near("out", d[0], mt[i][7:0]);
         near("dbg", d[2], mt[i][8] ? 64 : 0);
      end
      // internal low power bypass with the internal stop enable set
      xfer(1'b1, clk_src_pkg::ctrl_one_off, 8'h45);
      xfer(1'b1, clk_src_pkg::ctrl_two_off, 8'h48);
      background_debug <= 1'b1;
      repeat (2) @(posedge pclk);
      check("dbg loop", {31'h0, loop_enable}, 32'h0000_0001);
      background_debug <= 1'b0;
      regulator_stop_enable <= 1'b1;
      stop_req <= 1'b1;
      measure(256);
      check("stop", {29'h0, mode_status}, 32'h0000_0006);
      check("int stop", {31'h0, internal_ref_run}, 32'h0000_0001);
      check("ext stop", {31'h0, external_clock_enable},
         32'h0000_0000);
      near("stop out", d[0] + d[2], 0);
      stop_req <= 1'b0;
      for (int b = 0; b < 4; b++) begin
         xfer(1'b1, clk_src_pkg::ctrl_two_off, b << 6);
         measure(256);
         near("bus div", d[0], 64 >> b);
         near("bus", d[1], 32 >> b);
      end
      for (int r = 0; r < 8; r++) begin
         xfer(1'b1, clk_src_pkg::ctrl_one_off, (r << 3) | 4);
         measure(1024);
         near("ref div", d[3], 256 >> r);
      end
      xfer(1'b1, clk_src_pkg::ctrl_two_off, 8'h37);
      check("osc", {27'h0, oscillator_gain_select, oscillator_range_select,
         external_source_request, external_clock_enable,
         external_stop_enable}, 32'h0000_001f);
      xfer(1'b1, clk_src_pkg::ctrl_two_off, 8'h25);
      check("osc", {27'h0, oscillator_gain_select, oscillator_range_select,
         external_source_request, external_clock_enable,
         external_stop_enable}, 32'h0000_000d);
      xfer(1'b1, clk_src_pkg::trim_off, 8'h3c);
      xfer(1'b1, clk_src_pkg::status_off, 1);
      check("trim out", {23'h0, internal_trim}, 32'h0000_0079);
      rd("status", clk_src_pkg::status_off, 32'h0000_0013);
      complete_run();
   end
   // bound on the whole run
   initial begin
      repeat (100000) @(posedge pclk);
      fail_count++;
      complete_run();
   end
endmodule
bind clock_source_block fll_checker u_chk (.pclk(pclk), .presetn(presetn),
   .stop_req(stop_req), .internal_ref_en(internal_ref_en),
   .external_ref_en(external_ref_en),
   .controlled_oscillator_en(controlled_oscillator_en),
   .final_output_clock(final_output_clock), .bus_clock_en(bus_clock_en),
   .debug_clock(debug_clock), .loop_enable(loop_enable),
   .loop_reference_en(loop_reference_en), .mode_status(mode_status));
